//--- src/rtc_calendar_top.sv
// clock calendar core with 56-byte ram behind a two-wire serial slave
`timescale 1ns/1ps
`include "rtc_cfg.svh"
// How it works
// - start, address, then bytes with auto-increment
// - access blocked while power-good is low
// - access stays blocked for recovery after return
// - battery sealed until main power first good
// - power-on time 01/01/00 01 00:00:00, run
// - clock at 00h-07h, ram 08h-3Fh
// - pointer wraps from 3Fh to 00h
// - start or wrap copies time to read buffer
// - all time fields counted in bcd
// - seconds bit 7 halts counting; 32k wave output keeps running
// - weekday steps 1 to 7 at midnight
// - date rolls per month length and leap
// - seconds write restarts oscillator sub-second chain, not the reference count
// - written byte transferred on its acknowledge
// - 1hz wave rises 500ms after seconds write
// - hours bit 6 selects 12h, bit 5 pm/20
// - illegal time values give undefined results
// - fixed zero bits always read zero
// - oscillator glitches under 5us rejected on main power
// - wave pin outputs four rates or takes reference
// - reference enable low: pin is open drain
// - respond only to own seven-bit address
// - oscillator-stopped flag sticky, cleared by writing zero
// - recovery delay typically 1ms, at most 2ms
module rtc_calendar_top import rtc_pkg::*; #(
	parameter int REC_CYCLES = `RTC_REC_US * `RTC_CLK_MHZ
) (
	input wire logic mclk, // 100 mhz clock
	input wire logic rst, // synchronous reset, power-on
	input wire logic scl_in, // serial clock pin
	input wire logic sda_in, // serial data pin level
	output logic sda_out, // serial data drive value, always low
	output logic sda_oe, // serial data pull-down enable
	input wire logic osc_in, // crystal oscillator output
	input wire logic power_good_in, // main supply above threshold
	input wire logic battery_in, // backup battery attached
	input wire logic wave_in, // wave_or_ref_pin level
	output logic wave_out, // wave_or_ref_pin drive value
	output logic wave_oe, // wave_or_ref_pin pull-down enable
	output logic backup_power_on // running from battery
);
	rtc_time_t time_r, time_nxt, snap_r;
	rtc_bus_evt_t evt;
	logic i2c_oe;
	logic [7:0] ctrl_r, tx_byte, h_inc;
	logic [7:0] ram_r [0:55];
	logic [5:0] ptr_r;
	logic first_r, data_wr, ptr_step, sec_wr, ch, ch_p_r;
	logic [2:0] pg_s_r, bat_s_r, osc_s_r, ref_s_r;
	logic pg_r, bat_r, osc_lvl_r, osc_f_r, osc_p_r, ref_lvl_r, ref_p_r;
	logic [31:0] rec_cnt_r;
	logic access_ok_r, sealed_r;
	logic [9:0] glitch_cnt_r;
	logic [14:0] subsec_r, ref_cnt_r, ref_last;
	logic osc_edge, ref_edge, sec_tick, wave_lvl;
	logic c_min, c_hr, c_day, c_mon, c_yr;

	function automatic logic [7:0] bcd_inc(input logic [7:0] v);
		bcd_inc = (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : {v[7:4], v[3:0] + 4'h1};
	endfunction

	function automatic logic [7:0] month_len(input logic [7:0] mon, input logic [7:0] yr);
		logic leap;
		leap = yr[4] ? (yr[3:0] == 4'h2 || yr[3:0] == 4'h6) :
			(yr[3:0] == 4'h0 || yr[3:0] == 4'h4 || yr[3:0] == 4'h8);
		if (mon == 8'h02) begin
			month_len = leap ? 8'h29 : 8'h28;
		end else if (mon == 8'h04 || mon == 8'h06 || mon == 8'h09 || mon == 8'h11) begin
			month_len = 8'h30;
		end else begin
			month_len = 8'h31;
		end
	endfunction

	rtc_i2c_slave u_slave (
		.mclk(mclk),
		.rst(rst),
		.scl_pin(scl_in),
		.sda_pin(sda_in),
		.access_en(access_ok_r),
		.tx_byte(tx_byte),
		.evt(evt),
		.sda_oe(i2c_oe)
	);

	// ----------------------------------------
	// external level sampling
	// ----------------------------------------
	always_ff @(posedge mclk) begin
		if (rst) begin
			pg_s_r <= 3'h0;
			bat_s_r <= 3'h0;
			osc_s_r <= 3'h0;
			ref_s_r <= 3'h7;
			pg_r <= 1'b0;
			bat_r <= 1'b0;
			osc_lvl_r <= 1'b0;
			ref_lvl_r <= 1'b1;
			ref_p_r <= 1'b1;
		end else begin
			pg_s_r <= {pg_s_r[1:0], power_good_in};
			bat_s_r <= {bat_s_r[1:0], battery_in};
			osc_s_r <= {osc_s_r[1:0], osc_in};
			ref_s_r <= {ref_s_r[1:0], wave_in};
			if (pg_s_r[1] == pg_s_r[2]) begin
				pg_r <= pg_s_r[2];
			end
			if (bat_s_r[1] == bat_s_r[2]) begin
				bat_r <= bat_s_r[2];
			end
			if (osc_s_r[1] == osc_s_r[2]) begin
				osc_lvl_r <= osc_s_r[2];
			end
			if (ref_s_r[1] == ref_s_r[2]) begin
				ref_lvl_r <= ref_s_r[2];
			end
			ref_p_r <= ref_lvl_r;
		end
	end

	// ----------------------------------------
	// power fail blocking, recovery and battery seal
	// ----------------------------------------
	always_ff @(posedge mclk) begin
		if (rst) begin
			rec_cnt_r <= 32'h0;
			access_ok_r <= 1'b0;
			sealed_r <= 1'b1;
			backup_power_on <= 1'b0;
		end else begin
			if (!pg_r) begin
				rec_cnt_r <= 32'h0;
				access_ok_r <= 1'b0;
			end else if (rec_cnt_r == 32'(REC_CYCLES - 1)) begin
				access_ok_r <= 1'b1;
			end else begin
				rec_cnt_r <= rec_cnt_r + 32'h1;
			end
			if (pg_r) begin
				sealed_r <= 1'b0;
			end
			backup_power_on <= ~sealed_r & bat_r & ~pg_r;
		end
	end

	// ----------------------------------------
	// oscillator glitch filter and timebase
	// ----------------------------------------
	always_ff @(posedge mclk) begin
		if (rst) begin
			glitch_cnt_r <= 10'h000;
			osc_f_r <= 1'b0;
			osc_p_r <= 1'b0;
		end else begin
			osc_p_r <= osc_f_r;
			if (!pg_r || osc_lvl_r == osc_f_r) begin
				glitch_cnt_r <= 10'h000;
				osc_f_r <= osc_lvl_r;
			end else if (glitch_cnt_r == 10'(`RTC_GLITCH_CYC - 1)) begin
				glitch_cnt_r <= 10'h000;
				osc_f_r <= osc_lvl_r;
			end else begin
				glitch_cnt_r <= glitch_cnt_r + 10'h001;
			end
		end
	end

	assign ch = time_r.sec[`RTC_CH_BIT];
	assign osc_edge = osc_f_r & ~osc_p_r & ~ch;
	assign ref_edge = ref_lvl_r & ~ref_p_r & ctrl_r[`RTC_EXT_REF_INPUT_ENABLE_BIT];
	assign sec_wr = data_wr && ptr_r == `RTC_OFS_SEC;

	always_comb begin
		unique case (ctrl_r[1:0])
			2'b00: ref_last = `RTC_REF_LAST_1HZ;
			2'b01: ref_last = `RTC_REF_LAST_50HZ;
			2'b10: ref_last = `RTC_REF_LAST_60HZ;
			2'b11: ref_last = `RTC_REF_LAST_32K;
		endcase
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			subsec_r <= 15'h0000;
			ref_cnt_r <= 15'h0000;
			sec_tick <= 1'b0;
		end else begin
			if (sec_wr) begin
				subsec_r <= 15'h0000;
			end else if (osc_edge) begin
				subsec_r <= subsec_r + 15'h0001;
			end
			if (!ctrl_r[`RTC_EXT_REF_INPUT_ENABLE_BIT]) begin
				ref_cnt_r <= 15'h0000;
			end else if (ref_edge) begin
				ref_cnt_r <= (ref_cnt_r >= ref_last) ? 15'h0000 : ref_cnt_r + 15'h0001;
			end
			if (ctrl_r[`RTC_EXT_REF_INPUT_ENABLE_BIT]) begin
				sec_tick <= ref_edge && ref_cnt_r >= ref_last && !ch && !sec_wr;
			end else begin
				sec_tick <= osc_edge && subsec_r == `RTC_OSC_LAST && !sec_wr;
			end
		end
	end

	// ----------------------------------------
	// bcd time and calendar advance
	// ----------------------------------------
	always_comb begin
		time_nxt = time_r;
		c_min = 1'b0;
		c_hr = 1'b0;
		c_day = 1'b0;
		c_mon = 1'b0;
		c_yr = 1'b0;
		h_inc = bcd_inc(time_r.hr[`RTC_MODE12_BIT] ? {3'b000, time_r.hr[4:0]} :
			{2'b00, time_r.hr[5:0]});
		if (time_r.sec[6:0] == 7'h59) begin
			time_nxt.sec = 8'h00;
			c_min = 1'b1;
		end else begin
			time_nxt.sec = bcd_inc(time_r.sec);
		end
		if (c_min) begin
			if (time_r.min == 8'h59) begin
				time_nxt.min = 8'h00;
				c_hr = 1'b1;
			end else begin
				time_nxt.min = bcd_inc(time_r.min);
			end
		end
		if (c_hr) begin
			if (time_r.hr[`RTC_MODE12_BIT]) begin
				if (time_r.hr[4:0] == 5'h12) begin
					time_nxt.hr = {time_r.hr[7:5], 5'h01};
				end else if (time_r.hr[4:0] == 5'h11) begin
					time_nxt.hr = {time_r.hr[7:6], ~time_r.hr[`RTC_PM_BIT], 5'h12};
					c_day = time_r.hr[`RTC_PM_BIT];
				end else begin
					time_nxt.hr = {time_r.hr[7:5], h_inc[4:0]};
				end
			end else if (time_r.hr[5:0] == 6'h23) begin
				time_nxt.hr = {time_r.hr[7:6], 6'h00};
				c_day = 1'b1;
			end else begin
				time_nxt.hr = {time_r.hr[7:6], h_inc[5:0]};
			end
		end
		if (c_day) begin
			time_nxt.wday = (time_r.wday == 8'h07) ? 8'h01 : time_r.wday + 8'h01;
			if (time_r.date == month_len(time_r.mon, time_r.yr)) begin
				time_nxt.date = 8'h01;
				c_mon = 1'b1;
			end else begin
				time_nxt.date = bcd_inc(time_r.date);
			end
		end
		if (c_mon) begin
			if (time_r.mon == 8'h12) begin
				time_nxt.mon = 8'h01;
				c_yr = 1'b1;
			end else begin
				time_nxt.mon = bcd_inc(time_r.mon);
			end
		end
		if (c_yr) begin
			time_nxt.yr = (time_r.yr == 8'h99) ? 8'h00 : bcd_inc(time_r.yr);
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			time_r <= `RTC_RST_TIME;
		end else if (data_wr) begin
			unique case (ptr_r)
				`RTC_OFS_SEC: time_r.sec <= evt.data & `RTC_MASK_SEC;
				`RTC_OFS_MIN: time_r.min <= evt.data & `RTC_MASK_MIN;
				`RTC_OFS_HR: time_r.hr <= evt.data & `RTC_MASK_HR;
				`RTC_OFS_WDAY: time_r.wday <= evt.data & `RTC_MASK_WDAY;
				`RTC_OFS_DATE: time_r.date <= evt.data & `RTC_MASK_DATE;
				`RTC_OFS_MON: time_r.mon <= evt.data & `RTC_MASK_MON;
				`RTC_OFS_YR: time_r.yr <= evt.data & `RTC_MASK_YR;
				default: time_r <= time_r;
			endcase
		end else if (sec_tick) begin
			time_r <= time_nxt;
		end
	end

	// ----------------------------------------
	// register pointer and read snapshot
	// ----------------------------------------
	assign data_wr = evt.wr & ~first_r;
	assign ptr_step = data_wr | evt.rd_load;

	always_ff @(posedge mclk) begin
		if (rst) begin
			ptr_r <= 6'h00;
			first_r <= 1'b0;
		end else begin
			if (evt.addr_w) begin
				first_r <= 1'b1;
			end else if (evt.wr && first_r) begin
				first_r <= 1'b0;
				ptr_r <= evt.data[5:0];
			end else if (ptr_step) begin
				ptr_r <= ptr_r + 6'h01;
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			snap_r <= `RTC_RST_TIME;
		end else if (evt.start || (ptr_step && ptr_r == `RTC_OFS_TOP)) begin
			snap_r <= time_r;
		end
	end

	always_comb begin
		unique case (ptr_r)
			`RTC_OFS_SEC: tx_byte = snap_r.sec;
			`RTC_OFS_MIN: tx_byte = snap_r.min;
			`RTC_OFS_HR: tx_byte = snap_r.hr;
			`RTC_OFS_WDAY: tx_byte = snap_r.wday;
			`RTC_OFS_DATE: tx_byte = snap_r.date;
			`RTC_OFS_MON: tx_byte = snap_r.mon;
			`RTC_OFS_YR: tx_byte = snap_r.yr;
			`RTC_OFS_CTRL: tx_byte = ctrl_r;
			default: tx_byte = ram_r[ptr_r - `RTC_OFS_RAM];
		endcase
	end

	always_ff @(posedge mclk) begin
		if (data_wr && ptr_r >= `RTC_OFS_RAM) begin
			ram_r[ptr_r - `RTC_OFS_RAM] <= evt.data;
		end
	end

	// ----------------------------------------
	// control register with sticky status
	// ----------------------------------------
	always_ff @(posedge mclk) begin
		if (rst) begin
			ctrl_r <= `RTC_RST_CTRL;
			ch_p_r <= 1'b0;
		end else begin
			ch_p_r <= ch;
			if (data_wr && ptr_r == `RTC_OFS_CTRL) begin
				ctrl_r[7:6] <= evt.data[7:6];
				ctrl_r[4] <= evt.data[4];
				ctrl_r[2:0] <= evt.data[2:0];
				ctrl_r[`RTC_OSF_BIT] <= ctrl_r[`RTC_OSF_BIT] & evt.data[`RTC_OSF_BIT];
				ctrl_r[`RTC_LOS_BIT] <= ctrl_r[`RTC_LOS_BIT] & evt.data[`RTC_LOS_BIT];
			end
			if (ch && !ch_p_r) begin
				ctrl_r[`RTC_OSF_BIT] <= 1'b1;
			end
			if (!ctrl_r[`RTC_EXT_REF_INPUT_ENABLE_BIT] && !(data_wr && ptr_r == `RTC_OFS_CTRL &&
				evt.data[`RTC_EXT_REF_INPUT_ENABLE_BIT])) begin
				ctrl_r[`RTC_LOS_BIT] <= 1'b1;
			end
		end
	end

	// ----------------------------------------
	// square wave or reference pin
	// ----------------------------------------
	always_comb begin
		unique case (ctrl_r[1:0])
			2'b00: wave_lvl = subsec_r[14];
			2'b01: wave_lvl = subsec_r[2];
			2'b10: wave_lvl = subsec_r[1];
			2'b11: wave_lvl = osc_f_r;
		endcase
		if (!ctrl_r[`RTC_SQUARE_WAVE_ENABLE_BIT]) begin
			wave_lvl = ctrl_r[`RTC_OUT_BIT];
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			wave_out <= 1'b0;
			wave_oe <= 1'b0;
			sda_out <= 1'b0;
			sda_oe <= 1'b0;
		end else begin
			sda_oe <= i2c_oe;
			if (ctrl_r[`RTC_EXT_REF_INPUT_ENABLE_BIT] || (!pg_r && !ctrl_r[`RTC_BACKUP_PIN_ENABLE_BIT])) begin
				wave_oe <= 1'b0;
			end else begin
				wave_oe <= ~wave_lvl;
			end
		end
	end
endmodule

//--- src/rtc_cfg.svh
// constants for the serial real-time clock with calendar and backup ram
`ifndef RTC_CFG_SVH
`define RTC_CFG_SVH
`define RTC_SLAVE_ADDR 7'h68
`define RTC_OFS_SEC 6'h00
`define RTC_OFS_MIN 6'h01
`define RTC_OFS_HR 6'h02
`define RTC_OFS_WDAY 6'h03
`define RTC_OFS_DATE 6'h04
`define RTC_OFS_MON 6'h05
`define RTC_OFS_YR 6'h06
`define RTC_OFS_CTRL 6'h07
`define RTC_OFS_RAM 6'h08
`define RTC_OFS_TOP 6'h3f
`define RTC_MASK_SEC 8'hff
`define RTC_MASK_MIN 8'h7f
`define RTC_MASK_HR 8'h7f
`define RTC_MASK_WDAY 8'h07
`define RTC_MASK_DATE 8'h3f
`define RTC_MASK_MON 8'h1f
`define RTC_MASK_YR 8'hff
`define RTC_RST_TIME 56'h00_01_01_01_00_00_00
`define RTC_RST_CTRL 8'hbf
`define RTC_CH_BIT 7
`define RTC_MODE12_BIT 6
`define RTC_PM_BIT 5
`define RTC_OUT_BIT 7
`define RTC_EXT_REF_INPUT_ENABLE_BIT 6
`define RTC_OSF_BIT 5
`define RTC_SQUARE_WAVE_ENABLE_BIT 4
`define RTC_LOS_BIT 3
`define RTC_BACKUP_PIN_ENABLE_BIT 2
`define RTC_REF_LAST_1HZ 15'h0000
`define RTC_REF_LAST_50HZ 15'h0031
`define RTC_REF_LAST_60HZ 15'h003b
`define RTC_REF_LAST_32K 15'h7fff
`define RTC_OSC_LAST 15'h7fff
`define RTC_CLK_MHZ 100
`define RTC_GLITCH_NS 5000
`define RTC_GLITCH_CYC (`RTC_GLITCH_NS * `RTC_CLK_MHZ / 1000)
`define RTC_REC_US 1000
`endif

//--- src/rtc_pkg.sv
// types shared by the clock calendar and its serial slave
package rtc_pkg;
	typedef struct packed {
		logic [7:0] yr;
		logic [7:0] mon;
		logic [7:0] date;
		logic [7:0] wday;
		logic [7:0] hr;
		logic [7:0] min;
		logic [7:0] sec;
	} rtc_time_t;
	typedef struct packed {
		logic start;
		logic addr_w;
		logic wr;
		logic rd_load;
		logic [7:0] data;
	} rtc_bus_evt_t;
	typedef enum logic [2:0] {
		RTC_ST_IDLE = 3'b000,
		RTC_ST_ADDR = 3'b001,
		RTC_ST_WDATA = 3'b010,
		RTC_ST_ACK = 3'b011,
		RTC_ST_RDATA = 3'b100,
		RTC_ST_MACK = 3'b101
	} rtc_i2c_st_t;
endpackage

//--- src/rtc_i2c_slave.sv
// two-wire serial slave byte engine for the clock calendar
`timescale 1ns/1ps
`include "rtc_cfg.svh"
module rtc_i2c_slave import rtc_pkg::*; (
	input wire logic mclk, // system clock
	input wire logic rst, // synchronous reset
	input wire logic scl_pin, // serial clock pin level
	input wire logic sda_pin, // serial data pin level
	input wire logic access_en, // acknowledge allowed
	input wire logic [7:0] tx_byte, // byte to send on read
	output rtc_bus_evt_t evt, // bus event pulses
	output logic sda_oe // pull data line low
);
	logic [2:0] scl_s_r;
	logic [2:0] sda_s_r;
	logic scl_f_r, scl_p_r, sda_f_r, sda_p_r;
	logic rise, fall, start, stop;
	logic [7:0] sh_r;
	logic [2:0] bit_r;
	logic full_r, go_read_r;
	rtc_i2c_st_t st_r;

	// ----------------------------------------
	// pin sampling, change taken once stages agree
	// ----------------------------------------
	always_ff @(posedge mclk) begin
		if (rst) begin
			scl_s_r <= 3'h7;
			sda_s_r <= 3'h7;
			scl_f_r <= 1'b1;
			sda_f_r <= 1'b1;
			scl_p_r <= 1'b1;
			sda_p_r <= 1'b1;
		end else begin
			scl_s_r <= {scl_s_r[1:0], scl_pin};
			sda_s_r <= {sda_s_r[1:0], sda_pin};
			if (scl_s_r[1] == scl_s_r[2]) begin
				scl_f_r <= scl_s_r[2];
			end
			if (sda_s_r[1] == sda_s_r[2]) begin
				sda_f_r <= sda_s_r[2];
			end
			scl_p_r <= scl_f_r;
			sda_p_r <= sda_f_r;
		end
	end

	assign rise = scl_f_r & ~scl_p_r;
	assign fall = ~scl_f_r & scl_p_r;
	assign start = scl_f_r & scl_p_r & sda_p_r & ~sda_f_r;
	assign stop = scl_f_r & scl_p_r & ~sda_p_r & sda_f_r;

	// ----------------------------------------
	// byte sequencing
	// ----------------------------------------
	always_ff @(posedge mclk) begin
		if (rst) begin
			st_r <= RTC_ST_IDLE;
			sh_r <= 8'h00;
			bit_r <= 3'h0;
			full_r <= 1'b0;
			go_read_r <= 1'b0;
			sda_oe <= 1'b0;
			evt <= '0;
		end else begin
			evt.start <= 1'b0;
			evt.addr_w <= 1'b0;
			evt.wr <= 1'b0;
			evt.rd_load <= 1'b0;
			if (start) begin
				st_r <= RTC_ST_ADDR;
				bit_r <= 3'h0;
				full_r <= 1'b0;
				sda_oe <= 1'b0;
				evt.start <= 1'b1;
			end else if (stop) begin
				st_r <= RTC_ST_IDLE;
				sda_oe <= 1'b0;
			end else begin
				unique case (st_r)
					RTC_ST_IDLE: begin
						sda_oe <= 1'b0;
					end
					RTC_ST_ADDR, RTC_ST_WDATA: begin
						if (rise) begin
							sh_r <= {sh_r[6:0], sda_f_r};
							bit_r <= bit_r + 3'h1;
							full_r <= (bit_r == 3'h7);
						end else if (fall && full_r) begin
							full_r <= 1'b0;
							if (st_r == RTC_ST_ADDR) begin
								if (sh_r[7:1] == `RTC_SLAVE_ADDR && access_en) begin
									sda_oe <= 1'b1;
									go_read_r <= sh_r[0];
									evt.addr_w <= ~sh_r[0];
									st_r <= RTC_ST_ACK;
								end else begin
									st_r <= RTC_ST_IDLE;
								end
							end else if (access_en) begin
								sda_oe <= 1'b1;
								evt.wr <= 1'b1;
								evt.data <= sh_r;
								go_read_r <= 1'b0;
								st_r <= RTC_ST_ACK;
							end else begin
								st_r <= RTC_ST_IDLE;
							end
						end
					end
					RTC_ST_ACK, RTC_ST_MACK: begin
						if (rise && st_r == RTC_ST_MACK && sda_f_r) begin
							st_r <= RTC_ST_IDLE;
						end else if (fall) begin
							bit_r <= 3'h0;
							if (go_read_r || st_r == RTC_ST_MACK) begin
								sda_oe <= ~tx_byte[7];
								sh_r <= {tx_byte[6:0], 1'b0};
								evt.rd_load <= 1'b1;
								st_r <= RTC_ST_RDATA;
							end else begin
								sda_oe <= 1'b0;
								st_r <= RTC_ST_WDATA;
							end
						end
					end
					RTC_ST_RDATA: begin
						if (fall) begin
							bit_r <= bit_r + 3'h1;
							if (bit_r == 3'h7) begin
								sda_oe <= 1'b0;
								st_r <= RTC_ST_MACK;
							end else begin
								sda_oe <= ~sh_r[7];
								sh_r <= {sh_r[6:0], 1'b0};
							end
						end
					end
					default: begin
						st_r <= RTC_ST_IDLE;
					end
				endcase
			end
		end
	end
endmodule

//--- testbench/rtc_calendar_top_asserts.sv
// port checks for the clock calendar top
`timescale 1ns/1ps
module rtc_calendar_top_asserts #(
	parameter int REC_CYCLES = 100000
) (
	input wire logic mclk, // clock
	input wire logic rst, // reset
	input wire logic scl_in, // bus clock
	input wire logic sda_out, // data value
	input wire logic sda_oe, // data pull
	input wire logic power_good_in, // main good
	input wire logic battery_in, // battery
	input wire logic wave_out, // wave value
	input wire logic backup_power_on // on battery
);
	// ----
	// helpers
	// ----
	int rec_cnt;
	logic seen_r;
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (rst);
	always_ff @(posedge mclk) begin
		if (rst || !power_good_in) rec_cnt <= 0;
		else if (rec_cnt < REC_CYCLES) rec_cnt <= rec_cnt + 1;
	end
	always_ff @(posedge mclk) begin
		if (rst) seen_r <= 1'b0;
		else if (power_good_in) seen_r <= 1'b1;
	end
	sequence s_pg_low;
		!power_good_in [*8];
	endsequence
	sequence s_scl_rise;
		$rose(scl_in);
	endsequence
	sequence s_on_batt;
		(seen_r && battery_in && !power_good_in) [*8];
	endsequence
	// ----
	// checks
	// ----
	chk_sda_value_low: assert property (sda_out == 1'b0)
		else $error("sda value high");
	chk_wave_value_low: assert property (wave_out == 1'b0)
		else $error("wave value high");
	chk_pf_no_ack: assert property (s_pg_low |-> !sda_oe)
		else $error("ack while power low");
	chk_rec_no_ack: assert property (rec_cnt < REC_CYCLES |-> !sda_oe)
		else $error("ack in recovery");
	chk_scl_high_stable: assert property (s_scl_rise |-> $stable(sda_oe) [*8])
		else $error("sda moved with scl high");
	chk_seal_no_backup: assert property (!seen_r |-> !backup_power_on)
		else $error("backup while sealed");
	chk_no_battery: assert property (!battery_in [*8] |-> !backup_power_on)
		else $error("backup without battery");
	chk_main_power: assert property (power_good_in [*8] |-> !backup_power_on)
		else $error("backup with main power");
	chk_switch_over: assert property (s_on_batt |-> backup_power_on)
		else $error("no switch to backup");
	chk_reset_quiet: assert property ($fell(rst) |-> !sda_oe && !backup_power_on)
		else $error("outputs active after reset");
endmodule
bind rtc_calendar_top rtc_calendar_top_asserts #(.REC_CYCLES(REC_CYCLES)) u_chk (
	.mclk(mclk),
	.rst(rst),
	.scl_in(scl_in),
	.sda_out(sda_out),
	.sda_oe(sda_oe),
	.power_good_in(power_good_in),
	.battery_in(battery_in),
	.wave_out(wave_out),
	.backup_power_on(backup_power_on)
);

//--- testbench/rtc_bus_master.sv
// two-wire bus master model for the clock calendar
`timescale 1ns/1ps
module rtc_bus_master (
	input wire logic mclk, // clock
	input wire logic sda, // resolved data line
	output logic scl, // bus clock drive
	output logic sda_drv, // data drive, low pulls
	output logic got, // result strobe
	output logic [8:0] got_v // kind and value
);
	int hold = 20;
	initial begin
		scl = 1'b1;
		sda_drv = 1'b1;
		got = 1'b0;
		got_v = 9'h000;
	end
	task automatic ph();
		repeat (hold) @(posedge mclk);
		#1;
	endtask
	task automatic report(input logic [8:0] v);
		got_v = v;
		got = 1'b1;
		@(posedge mclk);
		#1;
		got = 1'b0;
	endtask
	// data only moves with scl low
	task automatic bit_io(input logic b, output logic r);
		ph();
		sda_drv = b;
		ph();
		scl = 1'b1;
		ph();
		r = sda;
		ph();
		scl = 1'b0;
	endtask
	task automatic start();
		ph();
		sda_drv = 1'b1;
		ph();
		scl = 1'b1;
		ph();
		sda_drv = 1'b0;
		ph();
		scl = 1'b0;
	endtask
	task automatic stop();
		ph();
		sda_drv = 1'b0;
		ph();
		scl = 1'b1;
		ph();
		sda_drv = 1'b1;
		ph();
	endtask
	task automatic byte_w(input logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) bit_io(d[i], r);
		bit_io(1'b1, r);
		report({1'b1, 7'h00, r});
	endtask
	task automatic byte_r(input logic last);
		logic [7:0] d;
		logic r;
		for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
		bit_io(last, r);
		report({1'b0, d});
	endtask
endmodule

//--- testbench/rtc_calendar_top_tb.sv
// self-checking bench for the clock calendar top
`timescale 1ns/1ps
module rtc_calendar_top_tb;
	localparam int REC = 20;
	logic mclk = 1'b0;
	logic rst = 1'b1;
	logic osc = 1'b0;
	logic pg = 1'b0;
	logic bat = 1'b1;
	logic scl, sda_drv, sda, sda_oe, sda_out, wave_in, wave_oe, wave_out, bkp, got;
	logic [8:0] got_v;
	logic [8:0] q[$];
	logic [7:0] r0, r1, r2;
	logic [7:0] cv[3] = '{8'h80, 8'h00, 8'h40};
	logic ov[3] = '{1'b0, 1'b1, 1'b0};
	int bad_count = 0;
	int comparisons = 0;
	int cyc = 0;
	assign sda = sda_drv & ~sda_oe;
	assign wave_in = ~wave_oe;
	always #5 mclk = ~mclk;
	always #7000 osc = ~osc;
	rtc_calendar_top #(.REC_CYCLES(REC)) u_rtc_calendar_top (
		.mclk(mclk),
		.rst(rst),
		.scl_in(scl),
		.sda_in(sda),
		.sda_out(sda_out),
		.sda_oe(sda_oe),
		.osc_in(osc),
		.power_good_in(pg),
		.battery_in(bat),
		.wave_in(wave_in),
		.wave_out(wave_out),
		.wave_oe(wave_oe),
		.backup_power_on(bkp)
	);
	rtc_bus_master u_rtc_bus_master (
		.mclk(mclk),
		.sda(sda),
		.scl(scl),
		.sda_drv(sda_drv),
		.got(got),
		.got_v(got_v)
	);
	// ----
	// helpers
	// ----
	task automatic tally_and_finish();
		if (bad_count == 0 && comparisons > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	task automatic check_bus(input logic [8:0] e, input logic [8:0] g);
		comparisons++;
		if (g !== e) begin
			bad_count++;
			$display("ERROR %0t bus got %h exp %h", $time, g, e);
		end
	endtask
	task automatic check_pin(input logic e, input logic g);
		comparisons++;
		if (g !== e) begin
			bad_count++;
			$display("ERROR %0t pin got %b exp %b", $time, g, e);
		end
	endtask
	task automatic wait_cyc(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask
	task automatic wb(input logic [7:0] v, input logic ak);
		q.push_back({1'b1, 7'h00, ak});
		u_rtc_bus_master.byte_w(v);
	endtask
	task automatic nak(input logic [7:0] a);
		u_rtc_bus_master.start();
		wb(a, 1'b1);
		u_rtc_bus_master.stop();
	endtask
	task automatic wr(input logic [7:0] p, input logic [7:0] d[$]);
		u_rtc_bus_master.start();
		wb(8'hd0, 1'b0);
		wb(p, 1'b0);
		foreach (d[i]) wb(d[i], 1'b0);
		u_rtc_bus_master.stop();
	endtask
	task automatic rd(input logic [7:0] p, input logic [7:0] e[$]);
		u_rtc_bus_master.start();
		wb(8'hd0, 1'b0);
		wb(p, 1'b0);
		u_rtc_bus_master.start();
		wb(8'hd1, 1'b0);
		foreach (e[i]) begin
			q.push_back({1'b0, e[i]});
			u_rtc_bus_master.byte_r(i == e.size() - 1);
		end
		u_rtc_bus_master.stop();
	endtask
	// ----
	// result watcher and watchdog
	// ----
	always @(posedge mclk) begin
		if (got === 1'b1) begin
			if (q.size() == 0) check_bus(9'h1ff, got_v);
			else check_bus(q.pop_front(), got_v);
		end
	end
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (cyc == 90000) begin
			bad_count++;
			tally_and_finish();
		end
	end
	// ----
	// main sequence
	// ----
	initial begin
		void'($urandom(5168));
		r0 = 8'($urandom());
		r1 = 8'($urandom());
		r2 = 8'($urandom());
		repeat (5) @(posedge mclk);
		#1;
		rst = 1'b0;
		wait_cyc(10);
		check_pin(1'b0, bkp);
		nak(8'hd0);
		pg = 1'b1;
		wait_cyc(REC + 20);
		nak(8'ha0);
		rd(8'h00, '{8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h01, 8'h00, 8'hbf});
		wr(8'h3e, '{r0, r1});
		wr(8'h08, '{r2});
		rd(8'h3e, '{r0, r1, 8'h00});
		wr(8'h01, '{8'hd9, 8'hd2, 8'hf5, 8'he9, 8'he2});
		rd(8'h01, '{8'h59, 8'h52, 8'h05, 8'h29, 8'h02});
		wr(8'h00, '{8'hb0});
		rd(8'h00, '{8'hb0, 8'h59});
		for (int i = 0; i < 3; i++) begin
			wr(8'h07, '{cv[i]});
			wait_cyc(10);
			check_pin(ov[i], wave_oe);
		end
		wr(8'h07, '{8'h20});
		rd(8'h07, '{8'h08});
		pg = 1'b0;
		wait_cyc(30);
		check_pin(1'b1, bkp);
		nak(8'hd1);
		pg = 1'b1;
		wait_cyc(REC + 20);
		check_pin(1'b0, bkp);
		u_rtc_bus_master.hold = 35;
		rd(8'h08, '{r2});
		bat = 1'b0;
		pg = 1'b0;
		wait_cyc(30);
		check_pin(1'b0, bkp);
		tally_and_finish();
	end
endmodule
